/* rtl/twm_pkg.sv */
// twm_pkg: constants, register map and shared types of the waveform timer.
// assumes a 32-bit classic wishbone master and a single clock domain.
// How it works
// - select zero leaves the waveform untouched
// - new select acts from next match
// - force strobe applies action in non-PWM modes
// - only the run bit steers counting, not PWM or slope
// - normal mode counts bottom to top, restarts
// - normal non-inverting clears at match, sets bottom
// - normal select one toggles at match
// - counter clears cycle after reaching top
// - normal overflow flag set when counter zero
// - interrupt service clears overflow flag
// - counter writable at any time
// - normal mode drives only the complementary pin
// - fast PWM counts single slope to top
// - fast PWM select two/three non-inverted/inverted
// - fast PWM select one gives complementary pair
// - fast PWM overflow flag set at top
// - fast PWM output returns at top wrap
// - extreme compare values give spike or level
// - pins overridden only when selected and output
// - fast PWM pin routing per select code
// - pin output lags waveform one clock
// - reset clears compare output state
package twm_pkg;
  localparam int CNT_W = 10;
  localparam int NCH = 3;
  localparam int ADR_W = 8;
  localparam logic [CNT_W-1:0] TOP_RST = 10'h0FF;
  localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] OFS_FORCE = 8'h04;
  localparam logic [ADR_W-1:0] OFS_COUNT = 8'h08;
  localparam logic [ADR_W-1:0] OFS_TOP = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h10;
  localparam logic [ADR_W-1:0] OFS_DIR = 8'h14;
  localparam logic [ADR_W-1:0] OFS_PORT = 8'h18;
  localparam logic [ADR_W-1:0] OFS_CMP0 = 8'h20;
  localparam logic [ADR_W-1:0] OFS_CMP_STEP = 8'h04;
  localparam int CTRL_PWM_BIT = 0;
  localparam int CTRL_SLOPE_BIT = 1;
  localparam int CTRL_RUN_BIT = 2;
  localparam int CTRL_COM_LSB = 4;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_WAVE_LSB = 4;
  localparam int STAT_OC_LSB = 8;
  localparam int PIN_TRUE_LSB = 0;
  localparam int PIN_COMP_LSB = 8;

  typedef enum logic [1:0] {
    COM_OFF = 2'h0,
    COM_TOGGLE = 2'h1,
    COM_NONINV = 2'h2,
    COM_INV = 2'h3
  } twm_com_t;

  typedef struct packed {
    twm_com_t com;
    logic pwm;
    logic dir_t;
    logic dir_c;
    logic port_t;
    logic port_c;
  } twm_chcfg_t;
endpackage

/* rtl/twm_chan.sv */
// twm_chan: waveform output of one compare channel.
// assumes match, bottom and force arrive as one-cycle pulses from the top.
`timescale 1ns/10ps
module twm_chan (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire twm_pkg::twm_com_t com_i,
  input wire logic pwm_i,
  input wire logic match_i,
  input wire logic bottom_i,
  input wire logic force_i,
  output logic wave_o
);
  import twm_pkg::*;

  typedef struct packed {
    logic wave;
  } twm_chan_state_t;

  twm_chan_state_t st_reg;
  twm_chan_state_t st_next;
  logic hit;

  always_comb begin
    st_next = st_reg;
    hit = match_i || (force_i && !pwm_i);
    case (com_i)
      COM_TOGGLE: begin
        if (pwm_i) begin
          if (bottom_i) st_next.wave = 1'b1;
          else if (hit) st_next.wave = 1'b0;
        end else if (hit) begin
          st_next.wave = ~st_reg.wave;
        end
      end
      COM_NONINV: begin
        // clear at match, set at bottom
        if (bottom_i) st_next.wave = 1'b1;
        else if (hit) st_next.wave = 1'b0;
      end
      COM_INV: begin
        // set at match, clear at bottom
        if (bottom_i) st_next.wave = 1'b0;
        else if (hit) st_next.wave = 1'b1;
      end
      default: st_next = st_reg;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign wave_o = st_reg.wave;
endmodule

/* rtl/twm_pinmux.sv */
// twm_pinmux: compare output stage and pin override of one channel.
// assumes the board resolves each pin from its value and output enable.
`timescale 1ns/10ps
module twm_pinmux (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire twm_pkg::twm_chcfg_t cfg_i,
  input wire logic wave_i,
  output logic oc_o,
  output logic pin_t_o,
  output logic pin_t_oe_o,
  output logic pin_c_o,
  output logic pin_c_oe_o
);
  import twm_pkg::*;

  typedef struct packed {
    logic oc;
    logic pin_t;
    logic oe_t;
    logic pin_c;
    logic oe_c;
  } twm_pin_state_t;

  twm_pin_state_t st_reg;
  twm_pin_state_t st_next;
  logic route_t;
  logic route_c;
  logic cval;

  always_comb begin
    // true pin only in PWM select one
    route_t = cfg_i.pwm && (cfg_i.com == COM_TOGGLE);
    route_c = (cfg_i.com != COM_OFF);
    cval = route_t ? ~wave_i : wave_i;
    st_next.oc = wave_i;
    // override needs select and output direction
    st_next.pin_t = (route_t && cfg_i.dir_t) ? wave_i : cfg_i.port_t;
    st_next.pin_c = (route_c && cfg_i.dir_c) ? cval : cfg_i.port_c;
    st_next.oe_t = cfg_i.dir_t;
    st_next.oe_c = cfg_i.dir_c;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign oc_o = st_reg.oc;
  assign pin_t_o = st_reg.pin_t;
  assign pin_t_oe_o = st_reg.oe_t;
  assign pin_c_o = st_reg.pin_c;
  assign pin_c_oe_o = st_reg.oe_c;
endmodule

/* rtl/twm_top.sv */
// twm_top: counter, compare channels and wishbone registers of the timer.
// assumes a classic wishbone master on clk_i and an interrupt controller
// that pulses ovf_ack_i when it services the overflow interrupt.
`timescale 1ns/10ps
module twm_top #(
  parameter int CNT_W = twm_pkg::CNT_W,
  parameter int NCH = twm_pkg::NCH,
  parameter logic [CNT_W-1:0] TOP_RST = twm_pkg::TOP_RST
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [twm_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ovf_ack_i,
  output logic ovf_flag_o,
  output logic [NCH-1:0] pin_t_o,
  output logic [NCH-1:0] pin_t_oe_o,
  output logic [NCH-1:0] pin_c_o,
  output logic [NCH-1:0] pin_c_oe_o
);
  import twm_pkg::*;

  typedef struct packed {
    logic pwm;
    logic slope;
    logic run;
    twm_com_t [NCH-1:0] com;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] top;
    logic [NCH-1:0][CNT_W-1:0] cmp;
    logic [NCH-1:0][CNT_W-1:0] cmp_buf;
    logic [NCH-1:0] dir_t;
    logic [NCH-1:0] dir_c;
    logic [NCH-1:0] port_t;
    logic [NCH-1:0] port_c;
    logic ovf;
    logic blk;
    logic ack;
    logic [31:0] rdat;
  } twm_top_state_t;

  twm_top_state_t st_reg;
  twm_top_state_t st_next;

  logic [NCH-1:0] wave;
  logic [NCH-1:0] oc;
  logic [NCH-1:0] match;
  logic [NCH-1:0] force_p;
  logic tick;
  logic wrap;
  logic [CNT_W-1:0] cnt_inc;
  logic [CNT_W-1:0] cnt_after;
  logic req;
  logic wr;
  logic [31:0] rd_v;
  logic [31:0] wr_v;
  logic hit_any;

  // byte-lane merge of a write into the current register image
  function automatic logic [31:0] wmerge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // address of compare register for channel idx
  function automatic logic [ADR_W-1:0] cmp_ofs(input int idx);
    logic [ADR_W-1:0] step;
    step = ADR_W'(idx) * OFS_CMP_STEP;
    return OFS_CMP0 + step;
  endfunction

  // register read image, also the base for byte-lane writes
  always_comb begin
    rd_v = '0;
    hit_any = 1'b1;
    case (wb_adr_i)
      OFS_CTRL: begin
        rd_v[CTRL_PWM_BIT] = st_reg.pwm;
        rd_v[CTRL_SLOPE_BIT] = st_reg.slope;
        rd_v[CTRL_RUN_BIT] = st_reg.run;
        for (int i = 0; i < NCH; i++) begin
          rd_v[CTRL_COM_LSB + 2*i +: 2] = st_reg.com[i];
        end
      end
      OFS_FORCE: rd_v = '0;
      OFS_COUNT: rd_v[CNT_W-1:0] = st_reg.cnt;
      OFS_TOP: rd_v[CNT_W-1:0] = st_reg.top;
      OFS_STATUS: begin
        rd_v[STAT_OVF_BIT] = st_reg.ovf;
        rd_v[STAT_WAVE_LSB +: NCH] = wave;
        rd_v[STAT_OC_LSB +: NCH] = oc;
      end
      OFS_DIR: begin
        rd_v[PIN_TRUE_LSB +: NCH] = st_reg.dir_t;
        rd_v[PIN_COMP_LSB +: NCH] = st_reg.dir_c;
      end
      OFS_PORT: begin
        rd_v[PIN_TRUE_LSB +: NCH] = st_reg.port_t;
        rd_v[PIN_COMP_LSB +: NCH] = st_reg.port_c;
      end
      default: begin
        hit_any = 1'b0;
        for (int i = 0; i < NCH; i++) begin
          if (wb_adr_i == cmp_ofs(i)) begin
            rd_v[CNT_W-1:0] = st_reg.cmp_buf[i];
            hit_any = 1'b1;
          end
        end
      end
    endcase
  end

  always_comb begin
    req = wb_cyc_i && wb_stb_i && !st_reg.ack;
    wr = req && wb_we_i;
    wr_v = wmerge(rd_v, wb_dat_i, wb_sel_i);
  end

  // advance once per tick, run bit only
  always_comb begin
    tick = st_reg.run;
    cnt_inc = st_reg.cnt + CNT_W'(1);
    // clear on the cycle after top
    wrap = tick && (st_reg.cnt == st_reg.top);
    if (!tick) begin
      cnt_after = st_reg.cnt;
    end else if (wrap) begin
      cnt_after = '0;
    end else begin
      cnt_after = cnt_inc;
    end
  end

  // match on equality, blocked after a count write
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      match[i] = tick && !st_reg.blk && (st_reg.cnt == st_reg.cmp[i]);
      force_p[i] = wr && (wb_adr_i == OFS_FORCE) && wb_sel_i[0] &&
                   wb_dat_i[i] && !st_reg.pwm;
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.cnt = cnt_after;
    if (tick) begin
      st_next.blk = 1'b0;
    end

    // compare values reload at the wrap in PWM modes
    if (wrap && st_reg.pwm) begin
      st_next.cmp = st_reg.cmp_buf;
    end

    // overflow flag only set by counting
    if (st_reg.pwm) begin
      if (tick && (cnt_after == st_reg.top)) begin
        st_next.ovf = 1'b1;
      end
    end else if (wrap) begin
      st_next.ovf = 1'b1;
    end

    // interrupt service clears; a new set wins
    if (ovf_ack_i && !st_next.ovf) begin
      st_next.ovf = 1'b0;
    end else if (ovf_ack_i && !(st_reg.pwm ?
        (tick && (cnt_after == st_reg.top)) : wrap)) begin
      st_next.ovf = 1'b0;
    end

    st_next.ack = req;
    if (req) begin
      st_next.rdat = hit_any ? rd_v : '0;
    end

    if (wr) begin
      case (wb_adr_i)
        OFS_CTRL: begin
          // new select takes effect on following events
          st_next.pwm = wr_v[CTRL_PWM_BIT];
          st_next.slope = wr_v[CTRL_SLOPE_BIT];
          st_next.run = wr_v[CTRL_RUN_BIT];
          for (int i = 0; i < NCH; i++) begin
            st_next.com[i] = twm_com_t'(wr_v[CTRL_COM_LSB + 2*i +: 2]);
          end
        end
        OFS_COUNT: begin
          // counter write accepted at any time
          st_next.cnt = wr_v[CNT_W-1:0];
          st_next.blk = 1'b1;
        end
        OFS_TOP: st_next.top = wr_v[CNT_W-1:0];
        OFS_STATUS: begin
          // write one clears, unless set this cycle
          if (wb_sel_i[0] && wb_dat_i[STAT_OVF_BIT]) begin
            if (!(st_reg.pwm ? (tick && (cnt_after == st_reg.top))
                : wrap)) begin
              st_next.ovf = 1'b0;
            end
          end
        end
        OFS_DIR: begin
          st_next.dir_t = wr_v[PIN_TRUE_LSB +: NCH];
          st_next.dir_c = wr_v[PIN_COMP_LSB +: NCH];
        end
        OFS_PORT: begin
          st_next.port_t = wr_v[PIN_TRUE_LSB +: NCH];
          st_next.port_c = wr_v[PIN_COMP_LSB +: NCH];
        end
        default: begin
          for (int i = 0; i < NCH; i++) begin
            if (wb_adr_i == cmp_ofs(i)) begin
              st_next.cmp_buf[i] = wr_v[CNT_W-1:0];
              // unbuffered in normal mode
              if (!st_reg.pwm) begin
                st_next.cmp[i] = wr_v[CNT_W-1:0];
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.top <= TOP_RST;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  generate
    for (genvar g = 0; g < NCH; g++) begin : g_ch
      twm_chcfg_t cfg;

      always_comb begin
        cfg.com = st_reg.com[g];
        cfg.pwm = st_reg.pwm;
        cfg.dir_t = st_reg.dir_t[g];
        cfg.dir_c = st_reg.dir_c[g];
        cfg.port_t = st_reg.port_t[g];
        cfg.port_c = st_reg.port_c[g];
      end

      // bottom event is the top-to-zero wrap, except in normal select one
      twm_chan u_chan (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .com_i(st_reg.com[g]),
        .pwm_i(st_reg.pwm),
        .match_i(match[g]),
        .bottom_i(wrap && (st_reg.pwm || st_reg.com[g] != COM_TOGGLE)),
        .force_i(force_p[g]),
        .wave_o(wave[g])
      );

      twm_pinmux u_pin (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .cfg_i(cfg),
        .wave_i(wave[g]),
        .oc_o(oc[g]),
        .pin_t_o(pin_t_o[g]),
        .pin_t_oe_o(pin_t_oe_o[g]),
        .pin_c_o(pin_c_o[g]),
        .pin_c_oe_o(pin_c_oe_o[g])
      );
    end
  endgenerate

  assign wb_dat_o = st_reg.rdat;
  assign wb_ack_o = st_reg.ack;
  assign ovf_flag_o = st_reg.ovf;
endmodule

/* dv/twm_top_asserts.sv */
// twm_top_chk: concurrent checks on the timer ports, bound to twm_top.
// assumes full-word bus writes, so sel is not tracked.
`timescale 1ns/10ps
module twm_top_chk #(
  parameter int NCH = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [twm_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic ovf_ack_i,
  input wire logic ovf_flag_o,
  input wire logic [NCH-1:0] pin_t_o,
  input wire logic [NCH-1:0] pin_t_oe_o,
  input wire logic [NCH-1:0] pin_c_o,
  input wire logic [NCH-1:0] pin_c_oe_o
);
  import twm_pkg::*;
  logic [9:0] ctrl_s;
  logic [10:0] dir_s, port_s;
  logic [1:0] quiet;
  logic [NCH-1:0] tdis, cdis;
  logic req, wr, ovf_w1c;
  assign req = wb_cyc_i && wb_stb_i;
  assign wr = req && wb_we_i && !wb_ack_o && ce_i;
  assign ovf_w1c = wr && wb_adr_i == OFS_STATUS && wb_dat_i[STAT_OVF_BIT];
  // shadow of the routing registers, quiet counts settled cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_s <= '0;
      dir_s <= '0;
      port_s <= '0;
      quiet <= '0;
    end else begin
      if (wr && wb_adr_i == OFS_CTRL) ctrl_s <= wb_dat_i[9:0];
      if (wr && wb_adr_i == OFS_DIR) dir_s <= wb_dat_i[10:0];
      if (wr && wb_adr_i == OFS_PORT) port_s <= wb_dat_i[10:0];
      if (wr) quiet <= '0;
      else if (ce_i && quiet != 2'h3) quiet <= quiet + 2'h1;
    end
  end
  // pins that must show the port bit
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      tdis[i] = !dir_s[i] || !ctrl_s[0] || ctrl_s[4+2*i +: 2] != 2'h1;
      cdis[i] = !dir_s[8+i] || ctrl_s[4+2*i +: 2] == 2'h0;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    req && !wb_ack_o && ce_i;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack_answer;
    s_req |=> s_pulse;
  endproperty
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(req);
  endproperty
  property p_reset_state;
    $fell(rst_i) |-> !wb_ack_o && !ovf_flag_o && pin_t_o == '0
      && pin_c_o == '0 && pin_t_oe_o == '0 && pin_c_oe_o == '0;
  endproperty
  property p_ovf_clear;
    $fell(ovf_flag_o) |-> $past(ovf_ack_i) || $past(ovf_w1c)
      || $past(rst_i);
  endproperty
  property p_freeze;
    !ce_i |=> $stable(pin_t_o) && $stable(pin_c_o) && $stable(ovf_flag_o);
  endproperty
  property p_oe_dir;
    quiet == 2'h3 |-> pin_t_oe_o == dir_s[NCH-1:0]
      && pin_c_oe_o == dir_s[8 +: NCH];
  endproperty
  property p_true_off;
    quiet == 2'h3 |-> (pin_t_o & tdis) == (port_s[NCH-1:0] & tdis);
  endproperty
  property p_comp_off;
    quiet == 2'h3 |-> (pin_c_o & cdis) == (port_s[8 +: NCH] & cdis);
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("request not answered by one ack pulse");
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  a_reset_state: assert property (p_reset_state)
    else $error("outputs not cleared by reset");
  a_ovf_clear: assert property (p_ovf_clear)
    else $error("overflow flag cleared without cause");
  a_freeze: assert property (p_freeze)
    else $error("state moved with clock enable low");
  a_oe_dir: assert property (p_oe_dir)
    else $error("pin enable differs from direction");
  a_true_off: assert property (p_true_off)
    else $error("true pin not showing port bit");
  a_comp_off: assert property (p_comp_off)
    else $error("comp pin not showing port bit");
endmodule

bind twm_top twm_top_chk #(.NCH(NCH)) i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .ovf_ack_i(ovf_ack_i), .ovf_flag_o(ovf_flag_o), .pin_t_o(pin_t_o),
  .pin_t_oe_o(pin_t_oe_o), .pin_c_o(pin_c_o), .pin_c_oe_o(pin_c_oe_o));

/* dv/twm_switch_model.sv */
// twm_switch_model: external switches on the true and comp pins.
// assumes no pull resistors; an undriven line reads the inverse of its last driven level.
`timescale 1ns/10ps
module twm_switch_model #(
  parameter int NCH = 3
) (
  input wire logic clk_i,
  input wire logic [NCH-1:0] pin_t_i,
  input wire logic [NCH-1:0] pin_t_oe_i,
  input wire logic [NCH-1:0] pin_c_i,
  input wire logic [NCH-1:0] pin_c_oe_i,
  output logic [NCH-1:0] line_t_o,
  output logic [NCH-1:0] line_c_o
);
  logic [NCH-1:0] last_t = '0;
  logic [NCH-1:0] last_c = '0;
  // keep the last driven level; a released line shows its inverse
  always @(posedge clk_i) begin
    last_t <= (pin_t_oe_i & pin_t_i) | (~pin_t_oe_i & last_t);
    last_c <= (pin_c_oe_i & pin_c_i) | (~pin_c_oe_i & last_c);
  end
  assign line_t_o = (pin_t_oe_i & pin_t_i) | (~pin_t_oe_i & ~last_t);
  assign line_c_o = (pin_c_oe_i & pin_c_i) | (~pin_c_oe_i & ~last_c);
endmodule

/* dv/timer_waveform_modes_normal_fast_pwm_tb_top.sv */
// testbench: drives the timer over wishbone and counts pin levels.
// assumes the switch model and the bound checker beside the design.
`timescale 1ns/10ps
module timer_waveform_modes_normal_fast_pwm_tb_top;
  import twm_pkg::*;
  logic clk_i = 0, rst_i = 1, ce_i = 1, cyc = 0, stb = 0, we = 0, oack = 0;
  logic [ADR_W-1:0] adr = '0;
  logic [31:0] wd = '0, rd, rv;
  logic ack, flag;
  logic [NCH-1:0] pt, pte, pc, pce, lt, lc;
  int mismatches = 0, checks = 0, ht, hc;
  int et[8] = '{0, 0, 0, 0, 0, 4, 0, 0};
  int ec[8] = '{16, 8, 4, 12, 16, 12, 4, 12};
  logic [7:0] fc[4] = '{8'h20, 8'h30, 8'h10, 8'h31};
  int fe[4] = '{0, 1, 0, 0};
  initial forever #12.5 clk_i = ~clk_i;
  twm_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .ovf_ack_i(oack),
    .ovf_flag_o(flag), .pin_t_o(pt), .pin_t_oe_o(pte), .pin_c_o(pc),
    .pin_c_oe_o(pce));
  twm_switch_model i_sw (.clk_i(clk_i), .pin_t_i(pt), .pin_t_oe_i(pte),
    .pin_c_i(pc), .pin_c_oe_i(pce), .line_t_o(lt), .line_c_o(lc));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [ADR_W-1:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      n++;
      if (n > 20) begin
        mismatches++;
        $display("unexpected at %0t: no ack", $time);
        complete_run();
      end
      @(posedge clk_i);
    end
    rv = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic count;
    ht = 0;
    hc = 0;
    repeat (16) begin
      @(posedge clk_i);
      if (lt[0] === 1'b1) ht++;
      if (lc[0] === 1'b1) hc++;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk(rv, 32'h0, "ctrl after reset");
    bus(1'b0, OFS_TOP, 32'h0);
    chk(rv, 32'(TOP_RST), "top after reset");
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rv, 32'h0, "status after reset");
    bus(1'b0, 8'h3C, 32'h0);
    chk(rv, 32'h0, "unmapped read");
    $display("reset test done");
    bus(1'b1, OFS_TOP, 32'h3);
    bus(1'b1, OFS_CMP0, 32'h0);
    bus(1'b1, OFS_DIR, 32'h101);
    bus(1'b1, OFS_PORT, 32'h100);
    // index bits: select code in the low two, pwm above
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, OFS_CTRL, 32'((m % 4) * 16 + 4 + m / 4));
      repeat (8) @(posedge clk_i);
      count();
      chk(32'(ht), 32'(et[m]), "true pin highs");
      chk(32'(hc), 32'(ec[m]), "comp pin highs");
    end
    $display("mode test done");
    bus(1'b1, OFS_CTRL, 32'h0);
    oack <= 1'b1;
    @(posedge clk_i);
    oack <= 1'b0;
    @(posedge clk_i);
    chk(32'(flag), 32'h0, "overflow serviced");
    bus(1'b1, OFS_COUNT, 32'h2);
    bus(1'b0, OFS_COUNT, 32'h0);
    chk(rv, 32'h2, "counter write");
    // from count one: pwm flags on reaching top, normal one clock later
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, OFS_CTRL, 32'h0);
      bus(1'b1, OFS_STATUS, 32'h1);
      chk(32'(flag), 32'h0, "overflow written off");
      bus(1'b1, OFS_COUNT, 32'h1);
      bus(1'b1, OFS_CTRL, 32'(4 + p));
      @(negedge clk_i);
      chk(32'(flag), 32'(p), "overflow before wrap");
      @(negedge clk_i);
      chk(32'(flag), 32'h1, "overflow at wrap");
      @(posedge clk_i);
    end
    $display("overflow test done");
    // clear, set, toggle, then a pwm force that must be ignored
    for (int f = 0; f < 4; f++) begin
      bus(1'b1, OFS_CTRL, 32'(fc[f]));
      bus(1'b1, OFS_FORCE, 32'h1);
      repeat (3) @(posedge clk_i);
      chk(32'(lc[0]), 32'(fe[f]), "forced level");
      chk(32'(lt[0]), 32'h0, "true pin idle");
    end
    $display("force test done");
    bus(1'b1, OFS_CTRL, 32'h14);
    ce_i <= 1'b0;
    @(posedge clk_i);
    hc = lc[0];
    // four ticks hold exactly one toggle if the clock enable leaks
    repeat (4) @(posedge clk_i);
    chk(32'(lc[0]), 32'(hc), "frozen pin");
    ce_i <= 1'b1;
    bus(1'b1, OFS_CTRL, 32'h0);
    $display("freeze test done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, OFS_DIR, 32'h0);
    chk(rv, 32'h0, "dir after reset");
    $display("second reset test done");
    complete_run();
  end
endmodule
